// ==== src_pkg.sv ====
package src_pkg;
   // Register map: one word, decoded at the full 32-bit printed address
   localparam logic [31:0] SRC_CTRL_ADDR = 32'hd003_0018;
   localparam int SRC_ADDR_W = 32;
   localparam int SRC_DATA_W = 32;
   // Bit positions of the pulse-type controls
   localparam int SRC_GLOBAL_BIT = 31;
   localparam int SRC_EBI_BIT = 20;
   // Level-type bits: 0..19 and 21..30
   localparam logic [31:0] SRC_LEVEL_MASK = 32'h7fef_ffff;
   localparam logic [31:0] SRC_CTRL_RESET = 32'h0000_0000;
   // Length of the chip-wide reset pulse in cycles
   localparam logic [3:0] SRC_GLOBAL_PULSE_CYC = 4'h8;
   localparam logic [3:0] SRC_CNT_ZERO = 4'h0;
   localparam logic [3:0] SRC_CNT_ONE = 4'h1;

   // Classic Wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [SRC_ADDR_W-1:0] adr;
      logic [SRC_DATA_W-1:0] dat;
   } src_wb_req_t;

   // Outputs toward the chip
   typedef struct packed {
      logic global_rst;
      logic ebi_rst;
      logic [31:0] periph_rst;
   } src_rst_out_t;

   // Slave states
   typedef enum logic [1:0] {
      SRC_IDLE = 2'b00,
      SRC_ACK = 2'b01
   } src_state_t;
endpackage

// ==== src_soft_reset_control.sv ====
`timescale 1ns/1ps
module src_soft_reset_control (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic global_rst_o,
   output logic ebi_rst_o,
   output logic [31:0] periph_rst_o
);

   // Merge byte lanes of a write into an old value
   function automatic logic [31:0] src_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   src_pkg::src_wb_req_t req;
   src_pkg::src_state_t state_r, state_nxt;
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic ack_r, ack_nxt;
   logic err_r, err_nxt;
   logic [3:0] gcnt_r, gcnt_nxt;
   logic ebi_r, ebi_nxt;
   logic hit;
   logic wr_go;
   logic [31:0] wval;

   // Bundle the bus inputs
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i};
   assign hit = (req.adr == src_pkg::SRC_CTRL_ADDR);
   // A write takes effect only at the acknowledging edge
   assign wr_go = (state_r == src_pkg::SRC_IDLE) && req.cyc && req.stb && req.we && hit;
   assign wval = src_merge(32'h0000_0000, req.dat, req.sel);

   // Bus slave and register next state; ack one cycle after request
   always_comb begin
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      rdat_nxt = rdat_r;
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      gcnt_nxt = gcnt_r;
      ebi_nxt = 1'b0;
      case (state_r)
         src_pkg::SRC_IDLE: begin
            if (req.cyc && req.stb) begin
               state_nxt = src_pkg::SRC_ACK;
               ack_nxt = hit;
               err_nxt = !hit;
               rdat_nxt = hit ? (ctrl_r & src_pkg::SRC_LEVEL_MASK) : 32'h0000_0000;
               if (wr_go) begin
                  // Each level bit in a selected byte lane follows its own written value
                  ctrl_nxt = src_merge(ctrl_r, req.dat, req.sel)
                             & src_pkg::SRC_LEVEL_MASK;
                  if (wval[src_pkg::SRC_GLOBAL_BIT]) begin
                     gcnt_nxt = src_pkg::SRC_GLOBAL_PULSE_CYC;
                  end
                  ebi_nxt = wval[src_pkg::SRC_EBI_BIT];
               end
            end
         end
         src_pkg::SRC_ACK: begin
            // One idle cycle so the master can release the strobe
            state_nxt = src_pkg::SRC_IDLE;
         end
         default: begin
            state_nxt = src_pkg::SRC_IDLE;
         end
      endcase
      if (gcnt_r != src_pkg::SRC_CNT_ZERO) begin
         gcnt_nxt = gcnt_r - src_pkg::SRC_CNT_ONE;
      end
   end

   // Registers; the global pulse also feeds back to clear the block
   always_ff @(posedge clk_i) begin
      if (rst_i || global_rst_o) begin
         state_r <= src_pkg::SRC_IDLE;
         ctrl_r <= src_pkg::SRC_CTRL_RESET;
         rdat_r <= 32'h0000_0000;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         ebi_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         rdat_r <= rdat_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
         ebi_r <= ebi_nxt;
      end
   end

   // Pulse counter survives its own pulse so the pulse runs its full length
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gcnt_r <= src_pkg::SRC_CNT_ZERO;
      end else begin
         gcnt_r <= gcnt_nxt;
      end
   end

   // Reset outputs straight from flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_rst_o <= 1'b0;
         ebi_rst_o <= 1'b0;
         periph_rst_o <= 32'h0000_0000;
      end else begin
         global_rst_o <= (gcnt_nxt != src_pkg::SRC_CNT_ZERO);
         ebi_rst_o <= ebi_nxt && !global_rst_o;
         // Software sets and clears each held reset; all of them are forced off one cycle behind the chip-wide pulse, for as long as it lasts
         periph_rst_o <= global_rst_o ? 32'h0000_0000 : ctrl_nxt;
      end
   end

   assign wb_dat_o = rdat_r;
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;

endmodule

// ==== src_chk_props.sv ====
`timescale 1ns/1ps
// Port lists are grouped to keep the checker short
module src_chk (
   input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, periph_rst_o,
   input wire logic wb_ack_o, wb_err_o, global_rst_o, ebi_rst_o
);
   // Request taken while slave idle, and whether it hits the register
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire hit = wb_adr_i == src_pkg::SRC_CTRL_ADDR;
   wire wr = tk && hit && wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_on_hit_a: assert property (tk && hit |=> wb_ack_o && !wb_err_o)
      else $error("no ack on register access");
   err_on_miss_a: assert property (tk && !hit |=> wb_err_o && $stable(periph_rst_o))
      else $error("unmapped access misbehaved");
   glob_trig_a: assert property (wr && wb_sel_i[3] && wb_dat_i[31] |=> global_rst_o)
      else $error("chip reset pulse missing");
   glob_len_a: assert property ($rose(global_rst_o) |-> global_rst_o [*8] ##1 !global_rst_o)
      else $error("chip reset pulse length wrong");
   ebi_pulse_a: assert property (wr && wb_sel_i[2] && wb_dat_i[20] |=> ebi_rst_o ##1 !ebi_rst_o)
      else $error("bus interface pulse wrong");
   rd_zero_a: assert property (wb_ack_o && !wb_we_i |-> !wb_dat_o[31] && !wb_dat_o[20])
      else $error("pulse bit read as one");
   per_zero_a: assert property (!periph_rst_o[31] && !periph_rst_o[20])
      else $error("pulse bit held as level");
   lvl_write_a: assert property (wr && wb_sel_i == 4'hf && !wb_dat_i[31]
      |=> periph_rst_o == ($past(wb_dat_i) & src_pkg::SRC_LEVEL_MASK))
      else $error("level bits not written");
   lvl_hold_a: assert property ($changed(periph_rst_o) |-> wb_ack_o || $past(global_rst_o))
      else $error("level reset changed alone");
   glob_clear_a: assert property ($rose(global_rst_o) |=> periph_rst_o == 32'h0)
      else $error("chip reset left levels set");
endmodule
bind src_soft_reset_control src_chk chk_u (.*);

// ==== tb_src_soft_reset_control.sv ====
`timescale 1ns/1ps
module tb_src_soft_reset_control;
   localparam logic [31:0] A = src_pkg::SRC_CTRL_ADDR;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, glob, ebi, ebi_seen;
   logic err_seen;
   logic [3:0] sel = 4'h0;
   logic [31:0] adr = 32'h0, dat = 32'h0, rd, dat_o, per;
   int err_count = 0, compares = 0;
   always #2 clk_i = ~clk_i;
   src_soft_reset_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .global_rst_o(glob), .ebi_rst_o(ebi), .periph_rst_o(per));
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One classic cycle; waits for ack or err, bounded so a dead slave cannot hang us
   task wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, s};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      // A slave that never answers is a failure, not a silent pass
      if (n >= 50) begin
         err_count++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      rd = dat_o;
      ebi_seen = ebi;
      err_seen = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task t_reset;
      wb(0, A, 0, 4'hf);
      chk(rd, 0);
      chk(per, 0);
   endtask
   task t_level;
      wb(1, A, 32'h7fff_ffff, 4'hf);
      chk(ebi_seen, 1);
      chk(per, 32'h7fef_ffff);
      wb(0, A, 0, 4'hf);
      chk(rd, 32'h7fef_ffff);
   endtask
   // Only the low lane is selected, so upper level bits must survive
   task t_subset;
      wb(1, A, 32'h0000_00f0, 4'h1);
      chk(per, 32'h7fef_fff0);
      wb(1, A + 32'h4, 0, 4'hf);
      chk(err_seen, 1);
      chk(per, 32'h7fef_fff0);
   endtask
   task t_global;
      wb(1, A, 32'h8000_0000, 4'hf);
      chk(glob, 1);
      repeat (10) @(posedge clk_i);
      chk(glob, 0);
      wb(0, A, 0, 4'hf);
      chk(rd, 0);
   endtask
   task print_verdict;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_level;
      t_subset;
      t_global;
      print_verdict;
   end
   // Watchdog well beyond the few dozen cycles the tests need
   initial begin
      #20000;
      err_count++;
      print_verdict;
   end
endmodule
